// ===== verilog/prfa_pkg.sv
// Shared constants for both ends of the partial-refresh pseudo-SRAM link
package prfa_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int WORDS = 4194304;
  localparam int BLK_MSB = 21;
  localparam int BLK_LSB = 20;
  localparam int CLK_NS = 10;
  localparam int T_MRS_NS = 500;
  localparam int T_WP_NS = 70;
  localparam int T_AA_NS = 70;
  localparam int T_PA_NS = 20;
  // Longest time rounds down, least times round up
  localparam logic [7:0] MRS_CYC = 8'(T_MRS_NS / CLK_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] AA_CYC = 8'((T_AA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PA_CYC = 8'((T_PA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] PAR_FULL = 2'h0;
  localparam logic [1:0] PAR_3Q = 2'h1;
  localparam logic [1:0] PAR_HALF = 2'h2;
  localparam logic [1:0] PAR_QUAR = 2'h3;
  localparam logic [1:0] DRV_FULL = 2'h0;
  localparam logic [1:0] DRV_HALF = 2'h1;
  localparam logic [1:0] DRV_QUAR = 2'h2;
  localparam logic [15:0] LOST_WORD = 16'hA5A5;
  localparam logic [1:0] PAGE_LAST = 2'h3;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RDATA0 = 8'h14;
  localparam logic [7:0] REG_RDATA1 = 8'h18;
  localparam logic [7:0] REG_RDATA2 = 8'h1C;
  localparam logic [7:0] REG_RDATA3 = 8'h20;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] WDATA_RST = 32'h0003_0000;
  localparam int CTRL_PAR_EN = 0;
  localparam int CTRL_PAR_TOP = 1;
  localparam int CTRL_SIZE_LSB = 2;
  localparam int CTRL_DRV_LSB = 4;
  localparam int CTRL_ENTER = 8;
  localparam int WD_LB = 16;
  localparam int WD_UB = 17;
  localparam int CMD_WR = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_PAGE = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_INIT = 1;
  localparam int ST_PAR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/prfa_if.sv
// Pin bundle between the pseudo-SRAM and its host controller
`timescale 1ns/1ns
interface prfa_if;
  logic chip_sel_n;
  logic write_en_n;
  logic out_en_n;
  logic upper_byte_strobe_n;
  logic lower_byte_strobe_n;
  logic mode_set_pin_n;
  logic address_valid_n;
  logic psram_clk;
  logic [prfa_pkg::ADDR_W-1:0] addr;
  logic [prfa_pkg::DATA_W-1:0] dq_host;
  logic dq_host_oe_n;
  logic [prfa_pkg::DATA_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic [prfa_pkg::DATA_W-1:0] dq;
  logic [1:0] dq_drive;
  logic wait_out;
  logic wait_oe_n;
  logic cfg_par_en;
  logic cfg_par_top;
  logic [1:0] cfg_par_size;
  logic [1:0] cfg_drive;

  // Wire level of the shared data bus; an idle bus reads as zero
  assign dq = !dq_dev_oe_n ? dq_dev : (!dq_host_oe_n ? dq_host : '0);

  modport dev (
    input chip_sel_n, write_en_n, out_en_n, upper_byte_strobe_n, lower_byte_strobe_n,
    input mode_set_pin_n, address_valid_n, psram_clk, addr, dq,
    input cfg_par_en, cfg_par_top, cfg_par_size, cfg_drive,
    output dq_dev, dq_dev_oe_n, dq_drive, wait_out, wait_oe_n
  );
  modport host (
    output chip_sel_n, write_en_n, out_en_n, upper_byte_strobe_n, lower_byte_strobe_n,
    output mode_set_pin_n, address_valid_n, psram_clk, addr, dq_host, dq_host_oe_n,
    output cfg_par_en, cfg_par_top, cfg_par_size, cfg_drive,
    input dq, dq_drive, wait_out, wait_oe_n
  );
endinterface

// ===== verilog/prfa_device.sv
// Pseudo-SRAM end: asynchronous access, partial array refresh, drive strength
`timescale 1ns/1ns
module prfa_device (
  input wire logic clk,
  input wire logic rst,
  prfa_if.dev bus
);
  typedef enum logic [1:0] {
    PRFA_NORMAL = 2'b00,
    PRFA_ARMED = 2'b01,
    PRFA_LIMITED = 2'b10
  } prfa_mode_e;

  logic [prfa_pkg::DATA_W-1:0] mem [0:prfa_pkg::WORDS-1];

  // True when a block lies inside the refreshed region
  function automatic logic kept(input logic [1:0] blk, input logic [1:0] size,
                                input logic top);
    logic [2:0] n;
    n = 3'(3'h4 - {1'b0, size});
    if (top) begin
      kept = {1'b0, blk} >= 3'(3'h4 - n);
    end else begin
      kept = {1'b0, blk} < n;
    end
  endfunction

  // Block index of a word address
  function automatic logic [1:0] blk_of(input logic [prfa_pkg::ADDR_W-1:0] a);
    blk_of = a[prfa_pkg::BLK_MSB:prfa_pkg::BLK_LSB];
  endfunction

  prfa_mode_e state;
  prfa_mode_e next_state;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  logic [1:0] held_size;
  logic [1:0] next_held_size;
  logic held_top;
  logic next_held_top;
  logic [3:0] lost;
  logic [3:0] next_lost;
  logic [3:0] drop;

  logic wr_act;
  logic next_wr_act;
  logic [prfa_pkg::ADDR_W-1:0] wr_addr;
  logic [prfa_pkg::ADDR_W-1:0] next_wr_addr;
  logic [prfa_pkg::DATA_W-1:0] wr_data;
  logic [prfa_pkg::DATA_W-1:0] next_wr_data;
  logic [1:0] wr_lanes;
  logic [1:0] next_wr_lanes;
  logic acc_ok;
  logic wr_now;
  logic commit;

  logic rd_now;
  logic [prfa_pkg::DATA_W-1:0] word;
  logic [prfa_pkg::DATA_W-1:0] dq_out;
  logic [prfa_pkg::DATA_W-1:0] next_dq_out;
  logic dq_oe_n;
  logic next_dq_oe_n;
  logic [1:0] drive;
  logic [1:0] next_drive;
  logic wait_q;
  logic wait_oe_q;

  // Blocks that stop being refreshed once the limited state is reached
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      drop[i] = !kept(2'(i), held_size, held_top);
    end
  end

  // Accesses are served in normal operation and during the short low window
  assign acc_ok = (state != PRFA_LIMITED);
  // Clock and address-valid pins take no part in an asynchronous cycle
  assign wr_now = !bus.chip_sel_n && !bus.write_en_n && acc_ok;
  assign commit = wr_act && !wr_now;
  assign rd_now = !bus.chip_sel_n && bus.write_en_n && !bus.out_en_n && acc_ok;

  // Mode-set pin tracking and refresh-limited state
  always_comb begin
    next_state = state;
    next_low_cnt = low_cnt;
    next_held_size = held_size;
    next_held_top = held_top;
    next_lost = lost;
    // A write into a block starts its contents afresh
    if (commit) begin
      next_lost[blk_of(wr_addr)] = 1'b0;
    end
    case (state)
      PRFA_NORMAL: begin
        if (!bus.mode_set_pin_n && bus.cfg_par_en) begin
          next_state = PRFA_ARMED;
          next_low_cnt = 8'h01;
          next_held_size = bus.cfg_par_size;
          next_held_top = bus.cfg_par_top;
        end
      end
      PRFA_ARMED: begin
        if (bus.mode_set_pin_n) begin
          next_state = PRFA_NORMAL;
          next_low_cnt = 8'h00;
        end else if (low_cnt >= prfa_pkg::MRS_CYC) begin
          next_state = PRFA_LIMITED;
          next_low_cnt = 8'h00;
          next_lost = next_lost | drop;
        end else begin
          next_low_cnt = 8'(low_cnt + 8'h01);
        end
      end
      PRFA_LIMITED: begin
        if (bus.mode_set_pin_n) begin
          next_state = PRFA_NORMAL;
        end
      end
      default: begin
        next_state = PRFA_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PRFA_NORMAL;
      low_cnt <= 8'h00;
      held_size <= prfa_pkg::PAR_FULL;
      held_top <= 1'b0;
      lost <= 4'h0;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      held_size <= next_held_size;
      held_top <= next_held_top;
      lost <= next_lost;
    end
  end

  // Write capture: the last overlap cycle holds the word that is stored
  always_comb begin
    next_wr_act = wr_now;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_lanes = wr_lanes;
    if (wr_now) begin
      next_wr_addr = bus.addr;
      next_wr_data = bus.dq;
      next_wr_lanes = {!bus.upper_byte_strobe_n, !bus.lower_byte_strobe_n};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_act <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lanes <= 2'h0;
    end else begin
      wr_act <= next_wr_act;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_lanes <= next_wr_lanes;
    end
  end

  // Array store, each byte lane under its own strobe, both lanes in the same cycle
  always_ff @(posedge clk) begin
    if (commit && wr_lanes[1]) begin
      mem[wr_addr][15:8] <= wr_data[15:8];
    end
    if (commit && wr_lanes[0]) begin
      mem[wr_addr][7:0] <= wr_data[7:0];
    end
  end

  // Read path follows the address every cycle, so words within a page
  // come out as fast as the host steps the two low address bits
  always_comb begin
    word = lost[blk_of(bus.addr)] ? prfa_pkg::LOST_WORD : mem[bus.addr];
    next_dq_out = '0;
    next_dq_oe_n = !rd_now;
    next_drive = drive;
    if (rd_now) begin
      next_drive = bus.cfg_drive;
      if (!bus.upper_byte_strobe_n) begin
        next_dq_out[15:8] = word[15:8];
      end
      if (!bus.lower_byte_strobe_n) begin
        next_dq_out[7:0] = word[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      drive <= prfa_pkg::DRV_FULL;
    end else begin
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
      drive <= next_drive;
    end
  end

  // The wait pin is never driven in asynchronous operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      wait_oe_q <= 1'b1;
    end else begin
      wait_q <= 1'b1;
      wait_oe_q <= 1'b1;
    end
  end

  assign bus.dq_dev = dq_out;
  assign bus.dq_dev_oe_n = dq_oe_n;
  assign bus.dq_drive = drive;
  assign bus.wait_out = wait_q;
  assign bus.wait_oe_n = wait_oe_q;
endmodule

// ===== verilog/prfa_host.sv
// Host end: AXI4-Lite registers driving asynchronous pseudo-SRAM cycles
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module prfa_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  prfa_if.host bus
);
  typedef enum logic [2:0] {
    PRFA_H_INIT = 3'b000,
    PRFA_H_IDLE = 3'b001,
    PRFA_H_WSET = 3'b010,
    PRFA_H_WPUL = 3'b011,
    PRFA_H_WEND = 3'b100,
    PRFA_H_RD = 3'b101
  } prfa_hstate_e;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = o;
  endfunction

  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] ctrl, next_ctrl, areg, next_areg, wreg, next_wreg;
  logic go_wr, go_rd, go_page;

  prfa_hstate_e st, next_st;
  logic [7:0] cnt, next_cnt;
  logic [1:0] idx, next_idx;
  logic page, next_page, init_done, next_init_done;
  logic [15:0] rd_word [0:3];
  logic [15:0] next_rd_word [0:3];
  logic cs_n, next_cs_n, we_n, next_we_n, oe_n, next_oe_n;
  logic ub_n, next_ub_n, lb_n, next_lb_n, dq_oe_n, next_dq_oe_n;
  logic mode_n, next_mode_n;
  logic [21:0] pin_addr, next_pin_addr;
  logic [15:0] dq_out, next_dq_out;

  // Register slave: address and data are taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_areg = areg;
    next_wreg = wreg;
    go_wr = 1'b0;
    go_rd = 1'b0;
    go_page = 1'b0;
    // An item moves only at an edge where its valid and ready are both high
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = prfa_pkg::RESP_OKAY;
      if (aw_addr == prfa_pkg::REG_CTRL) begin
        next_ctrl = merge(ctrl, w_data, w_strb);
      end else if (aw_addr == prfa_pkg::REG_ADDR) begin
        next_areg = merge(areg, w_data, w_strb);
      end else if (aw_addr == prfa_pkg::REG_WDATA) begin
        next_wreg = merge(wreg, w_data, w_strb);
      end else if (aw_addr == prfa_pkg::REG_CMD) begin
        // Commands while busy are dropped
        if (st == PRFA_H_IDLE && w_strb[0]) begin
          go_wr = w_data[prfa_pkg::CMD_WR];
          go_rd = !w_data[prfa_pkg::CMD_WR] && w_data[prfa_pkg::CMD_RD];
          go_page = go_rd && w_data[prfa_pkg::CMD_PAGE];
        end
      end else begin
        next_bresp = prfa_pkg::RESP_SLVERR;
      end
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = prfa_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr == prfa_pkg::REG_CTRL) begin
        next_rdata = ctrl;
      end else if (s_axi_araddr == prfa_pkg::REG_ADDR) begin
        next_rdata = areg;
      end else if (s_axi_araddr == prfa_pkg::REG_WDATA) begin
        next_rdata = wreg;
      end else if (s_axi_araddr == prfa_pkg::REG_CMD) begin
        next_rdata = 32'h0000_0000;
      end else if (s_axi_araddr == prfa_pkg::REG_STAT) begin
        next_rdata[prfa_pkg::ST_BUSY] = (st != PRFA_H_IDLE);
        next_rdata[prfa_pkg::ST_INIT] = init_done;
        next_rdata[prfa_pkg::ST_PAR] = !mode_n;
      end else if (s_axi_araddr == prfa_pkg::REG_RDATA0) begin
        next_rdata = {16'h0000, rd_word[0]};
      end else if (s_axi_araddr == prfa_pkg::REG_RDATA1) begin
        next_rdata = {16'h0000, rd_word[1]};
      end else if (s_axi_araddr == prfa_pkg::REG_RDATA2) begin
        next_rdata = {16'h0000, rd_word[2]};
      end else if (s_axi_araddr == prfa_pkg::REG_RDATA3) begin
        next_rdata = {16'h0000, rd_word[3]};
      end else begin
        next_rresp = prfa_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= prfa_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= prfa_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      ctrl <= prfa_pkg::CTRL_RST;
      areg <= prfa_pkg::ADDR_RST;
      wreg <= prfa_pkg::WDATA_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      areg <= next_areg;
      wreg <= next_wreg;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_arready <= !next_rvalid;
    end
  end

  // Pin sequencer
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_idx = idx;
    next_page = page;
    next_init_done = init_done;
    next_rd_word = rd_word;
    next_cs_n = cs_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_ub_n = ub_n;
    next_lb_n = lb_n;
    next_dq_oe_n = dq_oe_n;
    next_pin_addr = pin_addr;
    next_dq_out = dq_out;
    next_mode_n = !ctrl[prfa_pkg::CTRL_ENTER];
    case (st)
      PRFA_H_INIT, PRFA_H_IDLE: begin
        if (st == PRFA_H_INIT || go_rd) begin
          next_st = PRFA_H_RD;
          next_cs_n = 1'b0;
          next_oe_n = 1'b0;
          next_ub_n = 1'b0;
          next_lb_n = 1'b0;
          next_pin_addr = areg[21:0];
          next_cnt = 8'h00;
          next_idx = 2'h0;
          next_page = go_page;
        end else if (go_wr) begin
          next_st = PRFA_H_WSET;
          next_cs_n = 1'b0;
          next_pin_addr = areg[21:0];
          next_dq_out = wreg[15:0];
          next_dq_oe_n = 1'b0;
          // No lane selected means a whole word
          next_ub_n = !(wreg[prfa_pkg::WD_UB] || !wreg[prfa_pkg::WD_LB]);
          next_lb_n = !(wreg[prfa_pkg::WD_LB] || !wreg[prfa_pkg::WD_UB]);
        end
      end
      PRFA_H_WSET: begin
        next_st = PRFA_H_WPUL;
        next_we_n = 1'b0;
        next_cnt = 8'h00;
      end
      PRFA_H_WPUL: begin
        next_cnt = 8'(cnt + 8'h01);
        if (cnt == 8'(prfa_pkg::WP_CYC - 8'h01)) begin
          next_st = PRFA_H_WEND;
          next_we_n = 1'b1;
          next_cs_n = 1'b1;
        end
      end
      PRFA_H_WEND: begin
        next_st = PRFA_H_IDLE;
        next_dq_oe_n = 1'b1;
        next_ub_n = 1'b1;
        next_lb_n = 1'b1;
      end
      PRFA_H_RD: begin
        next_cnt = 8'(cnt + 8'h01);
        if (cnt == ((idx == 2'h0) ? prfa_pkg::AA_CYC : prfa_pkg::PA_CYC)) begin
          next_rd_word[idx] = bus.dq;
          next_cnt = 8'h00;
          if (page && idx != prfa_pkg::PAGE_LAST) begin
            next_idx = 2'(idx + 2'h1);
            next_pin_addr[1:0] = 2'(idx + 2'h1);
          end else begin
            next_st = PRFA_H_IDLE;
            next_init_done = 1'b1;
            next_cs_n = 1'b1;
            next_oe_n = 1'b1;
            next_ub_n = 1'b1;
            next_lb_n = 1'b1;
          end
        end
      end
      default: begin
        next_st = PRFA_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= PRFA_H_INIT;
      cnt <= 8'h00;
      idx <= 2'h0;
      page <= 1'b0;
      init_done <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_word[i] <= 16'h0000;
      end
      cs_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      ub_n <= 1'b1;
      lb_n <= 1'b1;
      dq_oe_n <= 1'b1;
      mode_n <= 1'b1;
      pin_addr <= 22'h00_0000;
      dq_out <= 16'h0000;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      idx <= next_idx;
      page <= next_page;
      init_done <= next_init_done;
      rd_word <= next_rd_word;
      cs_n <= next_cs_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      ub_n <= next_ub_n;
      lb_n <= next_lb_n;
      dq_oe_n <= next_dq_oe_n;
      mode_n <= next_mode_n;
      pin_addr <= next_pin_addr;
      dq_out <= next_dq_out;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign bus.chip_sel_n = cs_n;
  assign bus.write_en_n = we_n;
  assign bus.out_en_n = oe_n;
  assign bus.upper_byte_strobe_n = ub_n;
  assign bus.lower_byte_strobe_n = lb_n;
  assign bus.mode_set_pin_n = mode_n;
  assign bus.address_valid_n = 1'b1;
  assign bus.psram_clk = 1'b0;
  assign bus.addr = pin_addr;
  assign bus.dq_host = dq_out;
  assign bus.dq_host_oe_n = dq_oe_n;
  assign bus.cfg_par_en = ctrl[prfa_pkg::CTRL_PAR_EN];
  assign bus.cfg_par_top = ctrl[prfa_pkg::CTRL_PAR_TOP];
  assign bus.cfg_par_size = ctrl[prfa_pkg::CTRL_SIZE_LSB +: 2];
  assign bus.cfg_drive = ctrl[prfa_pkg::CTRL_DRV_LSB +: 2];
endmodule

// ===== bench/prfa_assertions.sv
// Pin-level checks on the link between host and pseudo-SRAM
`timescale 1ns/1ns
module prfa_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic [21:0] addr,
  input wire logic dq_dev_oe_n,
  input wire logic [1:0] dq_drive,
  input wire logic [1:0] cfg_drive,
  input wire logic wait_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence we_pulse;
    (!write_en_n && !chip_sel_n) [*7];
  endsequence
  sequence wr_end;
    write_en_n && chip_sel_n;
  endsequence
  chk_wait_undriven: assert property (wait_oe_n)
    else $error("wait output driven");
  chk_write_pulse: assert property ($fell(write_en_n) |-> we_pulse ##1 wr_end)
    else $error("write pulse shape wrong");
  chk_cs_leads_we: assert property ($fell(write_en_n) |-> $past(!chip_sel_n))
    else $error("write enable before select");
  chk_we_oe_excl: assert property (!write_en_n |-> out_en_n)
    else $error("output enable during write");
  chk_read_drive: assert property (!dq_dev_oe_n |-> $past(!chip_sel_n && !out_en_n))
    else $error("device drives outside read");
  chk_no_wr_drive: assert property (!write_en_n |-> dq_dev_oe_n)
    else $error("device drives during write");
  chk_drive_code: assert property (!dq_dev_oe_n && $past(!dq_dev_oe_n) |-> dq_drive == cfg_drive)
    else $error("drive code differs");
  chk_byte_lane: assert property (!write_en_n |-> !(upper_byte_strobe_n && lower_byte_strobe_n))
    else $error("write with no lane");
  chk_page_block: assert property (!chip_sel_n && $past(!chip_sel_n) && !out_en_n
    |-> addr[21:2] == $past(addr[21:2]))
    else $error("page left its four words");
endmodule

// ===== bench/prfa_tb_top.sv
// Bench joining host and device ends, driven over AXI4-Lite
`timescale 1ns/1ns
module psram_partial_refresh_async_access_tb_top;
  localparam logic [21:0] A0 = 22'h000010;
  localparam logic [21:0] A3 = 22'h300020;
  localparam logic [21:0] PB = 22'h100004;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int fail_count = 0, compares = 0, cyc = 0;
  prfa_if bus_if();
  prfa_device u_prfa_device(.clk(clk), .rst(rst), .bus(bus_if));
  prfa_host u_prfa_host(.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(bus_if));
  prfa_assertions u_chk(.clk(clk), .rst(rst), .chip_sel_n(bus_if.chip_sel_n),
    .write_en_n(bus_if.write_en_n), .out_en_n(bus_if.out_en_n), .addr(bus_if.addr),
    .upper_byte_strobe_n(bus_if.upper_byte_strobe_n), .dq_drive(bus_if.dq_drive),
    .lower_byte_strobe_n(bus_if.lower_byte_strobe_n), .dq_dev_oe_n(bus_if.dq_dev_oe_n),
    .cfg_drive(bus_if.cfg_drive), .wait_oe_n(bus_if.wait_oe_n));
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] er = prfa_pkg::RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ad = ad || awready;
      wd = wd || wready;
      @(posedge clk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge clk); while (!bvalid);
    check("bresp", 32'(bresp), 32'(er));
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(prfa_pkg::REG_CMD, c);
    do rd(prfa_pkg::REG_STAT); while (d[prfa_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic wword(input logic [21:0] a, input logic [31:0] v);
    wr(prfa_pkg::REG_ADDR, 32'(a));
    wr(prfa_pkg::REG_WDATA, v);
    cmd(32'h1);
  endtask
  task automatic rword(input logic [21:0] a, input logic [15:0] e, input string n);
    wr(prfa_pkg::REG_ADDR, 32'(a));
    cmd(32'h2);
    rd(prfa_pkg::REG_RDATA0);
    check(n, d, 32'(e));
  endtask
  task automatic t_page();
    for (int i = 0; i < 4; i++) begin
      wword(PB + 22'(i), 32'h0003_5A00 + 32'(i));
    end
    wr(prfa_pkg::REG_ADDR, 32'(PB));
    cmd(32'h6);
    for (int i = 0; i < 4; i++) begin
      rd(prfa_pkg::REG_RDATA0 + 8'(4 * i));
      check("page", d, 32'h0000_5A00 + 32'(i));
    end
  endtask
  task automatic t_drive();
    for (int i = 0; i < 3; i++) begin
      wr(prfa_pkg::REG_CTRL, 32'(i) << 4);
      rword(A0, 16'hABCD, "drv_read");
      check("drive", 32'(bus_if.dq_drive), 32'(i));
    end
    wr(prfa_pkg::REG_CTRL, 32'h0);
  endtask
  task automatic park(input logic [31:0] ctl, input int w, input logic [15:0] e3,
    input logic [15:0] e0);
    wr(prfa_pkg::REG_CTRL, ctl | 32'h100);
    repeat (w) @(posedge clk);
    rd(prfa_pkg::REG_STAT);
    check("pin_low", 32'(d[prfa_pkg::ST_PAR]), 32'h1);
    wr(prfa_pkg::REG_CTRL, ctl);
    rd(prfa_pkg::REG_STAT);
    check("pin_high", 32'(d[prfa_pkg::ST_PAR]), 32'h0);
    rword(A3, e3, "block3");
    rword(A0, e0, "block0");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    do rd(prfa_pkg::REG_STAT); while (d[prfa_pkg::ST_INIT] !== 1'b1);
    wword(A0, 32'h0003_1234);
    wword(A0, 32'h0001_00CD);
    wword(A0, 32'h0002_AB00);
    rword(A0, 16'hABCD, "lanes");
    t_page();
    t_drive();
    wr(8'h40, 32'h0, prfa_pkg::RESP_SLVERR);
    wr(prfa_pkg::REG_STAT, 32'h0, prfa_pkg::RESP_SLVERR);
    rd(8'h40);
    check("rresp", 32'(r), 32'(prfa_pkg::RESP_SLVERR));
    wword(A3, 32'h0003_7E57);
    park(32'h9, 20, 16'h7E57, 16'hABCD);
    park(32'h9, 60, prfa_pkg::LOST_WORD, 16'hABCD);
    wword(A3, 32'h0003_7E57);
    park(32'hF, 60, 16'h7E57, prfa_pkg::LOST_WORD);
    tally_and_finish();
  end
endmodule
